// File: orc_pkg.sv
package orc_pkg;
  // clock
  localparam int REF_CLK_PERIOD_NS = 8;
  // register access
  localparam logic [7:0] SETUP_OFFSET = 8'h84;
  localparam logic [7:0] CMD_READ_SETUP = 8'hDE;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h9E;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  // bits 15 and 28 are reserved and never stored
  localparam logic [31:0] SETUP_WRITE_MASK = 32'hEFFF_7FFF;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;
  // field positions
  localparam int PROC_LSB = 0;
  localparam int INDEX_LSB = 4;
  localparam int SRC2_LSB = 8;
  localparam int SRC3_LSB = 10;
  localparam int SRC4_LSB = 12;
  localparam int GATE_BIT = 14;
  localparam int EXT_CLR_LSB = 16;
  localparam int HOME_CLR_LSB = 20;
  localparam int CORR_LSB = 24;
  localparam int HOLD_LSB = 29;
  localparam int NUM_COUNTERS = 4;
  // homing procedure codes
  localparam logic [3:0] PROC_0 = 4'h0;
  localparam logic [3:0] PROC_1 = 4'h1;
  localparam logic [3:0] PROC_2 = 4'h2;
  localparam logic [3:0] PROC_3 = 4'h3;
  localparam logic [3:0] PROC_4 = 4'h4;
  localparam logic [3:0] PROC_5 = 4'h5;
  localparam logic [3:0] PROC_6 = 4'h6;
  localparam logic [3:0] PROC_7 = 4'h7;
  localparam logic [3:0] PROC_8 = 4'h8;
  localparam logic [3:0] PROC_9 = 4'h9;
  localparam logic [3:0] PROC_10 = 4'hA;
  localparam logic [3:0] PROC_11 = 4'hB;
  localparam logic [3:0] PROC_12 = 4'hC;
  localparam logic [3:0] INDEX_CNT_RESET = 4'h0;
  localparam logic [3:0] INDEX_CNT_STEP = 4'h1;
  // counter source codes
  localparam logic [1:0] SRC_CODE_0 = 2'h0;
  localparam logic [1:0] SRC_CODE_1 = 2'h1;
  localparam logic [1:0] SRC_CODE_2 = 2'h2;
  localparam logic [1:0] SRC_CODE_3 = 2'h3;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_SEEK  = 6'h02,
    ST_BACK  = 6'h04,
    ST_FWD   = 6'h08,
    ST_INDEX = 6'h10,
    ST_ZERO  = 6'h20
  } orc_state_type;
endpackage

// File: orc_cnt_if.sv
`timescale 1ns/1ns
interface orc_cnt_if;
  logic ext_clr_en;
  logic home_clr_en;
  logic corr_en;
  logic hold;
  logic src_up;
  logic src_dn;
  logic cnt_up;
  logic cnt_dn;
  logic cnt_clr;
  modport ctl (input ext_clr_en, home_clr_en, corr_en, hold, src_up, src_dn, output cnt_up, cnt_dn, cnt_clr);
  modport top (output ext_clr_en, home_clr_en, corr_en, hold, src_up, src_dn, input cnt_up, cnt_dn, cnt_clr);
endinterface

// File: orc_cnt_ctl.sv
`timescale 1ns/1ns
module orc_cnt_ctl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // shared events
  input wire logic i_ext_clr,
  input wire logic i_home_clr,
  input wire logic i_corr_active,
  // per-counter controls
  orc_cnt_if.ctl c
);
  wire allow = ~c.hold & (~i_corr_active | c.corr_en); // see RQ19
  wire clr_d = (i_ext_clr & c.ext_clr_en) | (i_home_clr & c.home_clr_en);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      c.cnt_up <= 1'b0;
      c.cnt_dn <= 1'b0;
      c.cnt_clr <= 1'b0;
    end else begin
      // simultaneous up and down cancel out
      c.cnt_up <= c.src_up & ~c.src_dn & allow; // see RQ20
      c.cnt_dn <= c.src_dn & ~c.src_up & allow;
      c.cnt_clr <= clr_d; // see RQ17
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_hold_stops_count: assert property (c.hold |=> !c.cnt_up && !c.cnt_dn) // see RQ20
    else $error("held counter still counts");
  a_ext_clear_sel: assert property ((i_ext_clr && c.ext_clr_en) |=> c.cnt_clr) // see RQ17
    else $error("external clear not passed on");
  a_home_clear_sel: assert property (!i_ext_clr && i_home_clr && !c.home_clr_en |=> !c.cnt_clr) // see RQ18
    else $error("home clear reached a disabled counter");
  a_corr_suppress: assert property ((i_corr_active && !c.corr_en) |=> !c.cnt_up && !c.cnt_dn) // see RQ19
    else $error("correction pulses counted while suppressed");
endmodule

// File: orc_top.sv
`timescale 1ns/1ns
// Function
// RQ1 - low four bits pick homing procedure
// RQ2 - proc 0 stops and clears on home
// RQ3 - proc 1 backs off, reapproaches, clears
// RQ4 - proc 2 stops on index count
// RQ5 - proc 3 stops or decelerates on index
// RQ6 - proc 4 reverses, stops on index count
// RQ7 - proc 5 reverses off home, index stop
// RQ8 - proc 6 limit stop, reverse, clear release
// RQ9 - proc 7 limit, reverse, index stop clear
// RQ10 - proc 8 limit stop, clear on index
// RQ11 - procs 9-12 then run to zero
// RQ12 - index count equals field plus one
// RQ13 - second counter source select
// RQ14 - third counter deviation source select
// RQ15 - fourth counter source select
// RQ16 - gate fourth counter by motion active
// RQ17 - per-counter external clear enables
// RQ18 - per-counter home clear enables
// RQ19 - per-counter correction pulse counting
// RQ20 - hold bits freeze counters two to four
// RQ21 - host uses direct address or commands
// RQ22 - reserved bits written zero, ignored
module orc_top (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  // direct register access
  input wire logic [7:0] I_BUS_ADDR,
  input wire logic I_BUS_WR,
  input wire logic I_BUS_RD,
  input wire logic [31:0] I_BUS_WDATA,
  // indirect command access
  input wire logic I_CMD_STB,
  input wire logic [7:0] I_CMD_CODE,
  input wire logic [31:0] I_CMD_WDATA,
  // read answer
  output logic [31:0] O_RDATA,
  output logic O_RDATA_VALID,
  // sensor pins
  input wire logic I_HOME_SENSOR,
  input wire logic I_LIMIT_SWITCH_INPUT,
  input wire logic I_ENCODER_INDEX,
  input wire logic I_COUNTER_RESET_INPUT,
  // motion context
  input wire logic I_HOMING_START,
  input wire logic I_HIGH_SPEED,
  input wire logic I_LIMIT_DECELERATE_OPTION,
  input wire logic I_MOTION_ACTIVE_OUTPUT,
  input wire logic I_CORRECTION_ACTIVE,
  input wire logic I_SECOND_COUNTER_ZERO,
  // count sources
  input wire logic I_COMMAND_PULSE,
  input wire logic I_ENCODER_PHASES,
  input wire logic I_MANUAL_PULSER_PHASES,
  // homing control
  output logic O_STOP_NOW,
  output logic O_DECEL_STOP,
  output logic O_REVERSE,
  output logic O_APPROACH_SPEED,
  output logic O_HOMING_BUSY,
  output logic O_ZERO_RUN,
  // counter strobes
  output logic [3:0] O_CNT_UP,
  output logic [3:0] O_CNT_DN,
  output logic [3:0] O_CNT_CLR
);
  logic [31:0] setup_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  orc_pkg::orc_state_type state_q;
  orc_pkg::orc_state_type state_d;
  logic [3:0] proc_q;
  logic [3:0] idx_cnt_q;
  logic [3:0] idx_cnt_d;
  logic stop_now_d;
  logic decel_d;
  logic clear_d;
  logic stop_q;
  logic decel_q;
  logic home_clr_q;
  logic reverse_q;
  logic approach_q;
  logic busy_q;
  logic zero_q;
  logic div_q;
  logic ext_clr_q;

  // register access decode
  wire direct_hit = (I_BUS_ADDR == orc_pkg::SETUP_OFFSET);
  wire wr_direct = I_BUS_WR & direct_hit;
  wire wr_cmd = I_CMD_STB & (I_CMD_CODE == orc_pkg::CMD_WRITE_SETUP);
  wire rd_direct = I_BUS_RD & direct_hit;
  wire rd_cmd = I_CMD_STB & (I_CMD_CODE == orc_pkg::CMD_READ_SETUP);
  // direct write wins if both paths write in one cycle
  wire [31:0] wr_data = wr_direct ? I_BUS_WDATA : I_CMD_WDATA;

  // fields
  wire [3:0] proc_field = setup_q[orc_pkg::PROC_LSB +: 4];
  wire [3:0] idx_field = setup_q[orc_pkg::INDEX_LSB +: 4];
  wire [1:0] src2_sel = setup_q[orc_pkg::SRC2_LSB +: 2];
  wire [1:0] src3_sel = setup_q[orc_pkg::SRC3_LSB +: 2];
  wire [1:0] src4_sel = setup_q[orc_pkg::SRC4_LSB +: 2];
  wire gate4 = setup_q[orc_pkg::GATE_BIT];
  wire [3:0] ext_clr_en = setup_q[orc_pkg::EXT_CLR_LSB +: 4];
  wire [3:0] home_clr_en = setup_q[orc_pkg::HOME_CLR_LSB +: 4];
  wire [3:0] corr_en = setup_q[orc_pkg::CORR_LSB +: 4];
  wire [3:0] hold = {setup_q[orc_pkg::HOLD_LSB +: 3], 1'b0};

  // synchronised pins and edges
  wire home_s = sync2_q[0];
  wire limit_s = sync2_q[1];
  wire home_rise = home_s & ~prev_q[0];
  wire home_fall = ~home_s & prev_q[0];
  wire limit_rise = limit_s & ~prev_q[1];
  wire limit_fall = ~limit_s & prev_q[1];
  wire idx_rise = sync2_q[2] & ~prev_q[2];
  wire ext_clr_rise = sync2_q[3] & ~prev_q[3];

  // procedures 9 to 12 reuse 0, 3, 5 and 8 as their first part
  wire zero_run_en = (proc_q >= orc_pkg::PROC_9); // see RQ11
  wire [3:0] base = (proc_q == orc_pkg::PROC_9) ? orc_pkg::PROC_0 :
                    (proc_q == orc_pkg::PROC_10) ? orc_pkg::PROC_3 :
                    (proc_q == orc_pkg::PROC_11) ? orc_pkg::PROC_5 :
                    (proc_q == orc_pkg::PROC_12) ? orc_pkg::PROC_8 : proc_q;
  wire limit_based = (base == orc_pkg::PROC_6) | (base == orc_pkg::PROC_7) | (base == orc_pkg::PROC_8);
  wire first_rise = limit_based ? limit_rise : home_rise;
  wire first_fall = limit_based ? limit_fall : home_fall;
  wire proc_ok = (proc_field <= orc_pkg::PROC_12); // see RQ1
  wire lim_dec = I_HIGH_SPEED & I_LIMIT_DECELERATE_OPTION;
  wire idx_done = idx_rise & (idx_cnt_q == idx_field); // see RQ12
  wire approach_proc = (base == orc_pkg::PROC_1) | (base == orc_pkg::PROC_4) |
                       (base == orc_pkg::PROC_6) | (base == orc_pkg::PROC_7);
  // back-off keeps its direction while index marks are counted
  wire index_rev = (base == orc_pkg::PROC_4) | (base == orc_pkg::PROC_5) | (base == orc_pkg::PROC_7); // see RQ6
  orc_pkg::orc_state_type finish_state;
  assign finish_state = zero_run_en ? orc_pkg::ST_ZERO : orc_pkg::ST_IDLE;

  always_comb begin
    state_d = state_q;
    idx_cnt_d = idx_cnt_q;
    stop_now_d = 1'b0;
    decel_d = 1'b0;
    clear_d = 1'b0;
    case (state_q)
      orc_pkg::ST_IDLE: begin
        if (I_HOMING_START && proc_ok) begin
          state_d = orc_pkg::ST_SEEK;
        end
      end
      orc_pkg::ST_SEEK: begin
        idx_cnt_d = orc_pkg::INDEX_CNT_RESET;
        if (first_rise) begin
          case (base)
            orc_pkg::PROC_0: begin
              stop_now_d = ~I_HIGH_SPEED; // see RQ2
              decel_d = I_HIGH_SPEED;
              clear_d = 1'b1;
              state_d = finish_state;
            end
            orc_pkg::PROC_1, orc_pkg::PROC_4, orc_pkg::PROC_5: begin
              stop_now_d = ~I_HIGH_SPEED; // see RQ3
              decel_d = I_HIGH_SPEED;
              state_d = orc_pkg::ST_BACK;
            end
            orc_pkg::PROC_2: begin
              // high speed starts braking on home, stop lands on index
              decel_d = I_HIGH_SPEED; // see RQ4
              state_d = orc_pkg::ST_INDEX;
            end
            orc_pkg::PROC_3: begin
              state_d = orc_pkg::ST_INDEX; // see RQ5
            end
            orc_pkg::PROC_6, orc_pkg::PROC_7: begin
              stop_now_d = ~lim_dec; // see RQ8
              decel_d = lim_dec;
              state_d = orc_pkg::ST_BACK;
            end
            orc_pkg::PROC_8: begin
              stop_now_d = ~lim_dec; // see RQ10
              decel_d = lim_dec;
              state_d = orc_pkg::ST_INDEX;
            end
            default: begin
              state_d = orc_pkg::ST_IDLE;
            end
          endcase
        end
      end
      orc_pkg::ST_BACK: begin
        idx_cnt_d = orc_pkg::INDEX_CNT_RESET;
        if (first_fall) begin
          case (base)
            orc_pkg::PROC_1: begin
              state_d = orc_pkg::ST_FWD; // see RQ3
            end
            orc_pkg::PROC_6: begin
              stop_now_d = 1'b1; // see RQ8
              clear_d = 1'b1;
              state_d = finish_state;
            end
            default: begin
              state_d = orc_pkg::ST_INDEX; // see RQ6
            end
          endcase
        end
      end
      orc_pkg::ST_FWD: begin
        if (home_rise) begin
          stop_now_d = 1'b1; // see RQ3
          clear_d = 1'b1;
          state_d = finish_state;
        end
      end
      orc_pkg::ST_INDEX: begin
        if (idx_done) begin
          // procedure 8 already stopped on the limit
          case (base)
            orc_pkg::PROC_3, orc_pkg::PROC_5: begin
              stop_now_d = ~I_HIGH_SPEED; // see RQ7
              decel_d = I_HIGH_SPEED;
            end
            orc_pkg::PROC_8: begin
              stop_now_d = 1'b0; // see RQ10
            end
            default: begin
              stop_now_d = 1'b1; // see RQ9
            end
          endcase
          clear_d = 1'b1;
          state_d = finish_state;
        end else if (idx_rise) begin
          idx_cnt_d = idx_cnt_q + orc_pkg::INDEX_CNT_STEP; // see RQ12
        end
      end
      orc_pkg::ST_ZERO: begin
        if (I_SECOND_COUNTER_ZERO) begin
          stop_now_d = 1'b1; // see RQ11
          state_d = orc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = orc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      setup_q <= orc_pkg::SETUP_RESET;
      rdata_q <= orc_pkg::READ_IDLE;
      rvalid_q <= 1'b0;
    end else begin
      if (wr_direct || wr_cmd) begin
        setup_q <= wr_data & orc_pkg::SETUP_WRITE_MASK; // see RQ22
      end
      rvalid_q <= rd_direct | rd_cmd; // see RQ21
      rdata_q <= (rd_direct | rd_cmd) ? setup_q : orc_pkg::READ_IDLE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sync1_q <= {I_COUNTER_RESET_INPUT, I_ENCODER_INDEX, I_LIMIT_SWITCH_INPUT, I_HOME_SENSOR};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      state_q <= orc_pkg::ST_IDLE;
      proc_q <= orc_pkg::PROC_0;
      idx_cnt_q <= orc_pkg::INDEX_CNT_RESET;
    end else begin
      state_q <= state_d;
      idx_cnt_q <= idx_cnt_d;
      // latched so a rewrite mid-run cannot switch procedure
      if (state_q == orc_pkg::ST_IDLE) begin
        proc_q <= proc_field;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      stop_q <= 1'b0;
      decel_q <= 1'b0;
      home_clr_q <= 1'b0;
      reverse_q <= 1'b0;
      approach_q <= 1'b0;
      busy_q <= 1'b0;
      zero_q <= 1'b0;
      div_q <= 1'b0;
      ext_clr_q <= 1'b0;
    end else begin
      stop_q <= stop_now_d;
      decel_q <= decel_d;
      home_clr_q <= clear_d;
      reverse_q <= (state_d == orc_pkg::ST_BACK) | ((state_d == orc_pkg::ST_INDEX) & index_rev); // see RQ7
      approach_q <= (((state_d == orc_pkg::ST_BACK) | (state_d == orc_pkg::ST_INDEX)) & approach_proc) |
                    (state_d == orc_pkg::ST_FWD); // see RQ9
      busy_q <= (state_d != orc_pkg::ST_IDLE);
      zero_q <= (state_d == orc_pkg::ST_ZERO);
      div_q <= ~div_q;
      ext_clr_q <= ext_clr_rise;
    end
  end

  // counter sources; code 3 counts nothing, except on the fourth counter, which counts div_q at half the clock rate
  wire src2 = (src2_sel == orc_pkg::SRC_CODE_0) ? I_ENCODER_PHASES : // see RQ13
              (src2_sel == orc_pkg::SRC_CODE_1) ? I_COMMAND_PULSE :
              (src2_sel == orc_pkg::SRC_CODE_2) ? I_MANUAL_PULSER_PHASES : 1'b0;
  wire src3_up = (src3_sel == orc_pkg::SRC_CODE_0) ? I_COMMAND_PULSE : // see RQ14
                 (src3_sel == orc_pkg::SRC_CODE_1) ? I_COMMAND_PULSE :
                 (src3_sel == orc_pkg::SRC_CODE_2) ? I_ENCODER_PHASES : 1'b0;
  wire src3_dn = (src3_sel == orc_pkg::SRC_CODE_0) ? I_ENCODER_PHASES :
                 (src3_sel == orc_pkg::SRC_CODE_1) ? I_MANUAL_PULSER_PHASES :
                 (src3_sel == orc_pkg::SRC_CODE_2) ? I_MANUAL_PULSER_PHASES : 1'b0;
  wire src4_raw = (src4_sel == orc_pkg::SRC_CODE_0) ? I_COMMAND_PULSE : // see RQ15
                  (src4_sel == orc_pkg::SRC_CODE_1) ? I_ENCODER_PHASES :
                  (src4_sel == orc_pkg::SRC_CODE_2) ? I_MANUAL_PULSER_PHASES : div_q;
  wire src4 = src4_raw & (~gate4 | ~I_MOTION_ACTIVE_OUTPUT); // see RQ16
  wire [3:0] src_up = {src4, src3_up, src2, I_COMMAND_PULSE};
  wire [3:0] src_dn = {1'b0, src3_dn, 1'b0, 1'b0};

  orc_cnt_if cif [orc_pkg::NUM_COUNTERS] ();
  genvar g;
  generate
    for (g = 0; g < orc_pkg::NUM_COUNTERS; g = g + 1) begin : g_cnt
      assign cif[g].ext_clr_en = ext_clr_en[g];
      assign cif[g].home_clr_en = home_clr_en[g]; // see RQ18
      assign cif[g].corr_en = corr_en[g];
      assign cif[g].hold = hold[g];
      assign cif[g].src_up = src_up[g];
      assign cif[g].src_dn = src_dn[g];
      assign O_CNT_UP[g] = cif[g].cnt_up;
      assign O_CNT_DN[g] = cif[g].cnt_dn;
      assign O_CNT_CLR[g] = cif[g].cnt_clr;
      orc_cnt_ctl u_ctl (
        .i_clk(I_REF_CLK),
        .i_srst(I_SRST),
        .i_ext_clr(ext_clr_q),
        .i_home_clr(home_clr_q),
        .i_corr_active(I_CORRECTION_ACTIVE),
        .c(cif[g])
      );
    end
  endgenerate

  assign O_RDATA = rdata_q;
  assign O_RDATA_VALID = rvalid_q;
  assign O_STOP_NOW = stop_q;
  assign O_DECEL_STOP = decel_q;
  assign O_REVERSE = reverse_q;
  assign O_APPROACH_SPEED = approach_q;
  assign O_HOMING_BUSY = busy_q;
  assign O_ZERO_RUN = zero_q;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);

  sequence s_p1_home_edge;
    state_q == orc_pkg::ST_SEEK && base == orc_pkg::PROC_1 && home_rise;
  endsequence
  sequence s_back_at_approach;
    state_q == orc_pkg::ST_BACK && O_REVERSE && O_APPROACH_SPEED;
  endsequence

  a_direct_write_mask: assert property (wr_direct |=> setup_q == ($past(I_BUS_WDATA) & orc_pkg::SETUP_WRITE_MASK)) // see RQ22
    else $error("direct write not stored with reserved bits cleared");
  a_cmd_read_back: assert property (rd_cmd && !rd_direct |=> O_RDATA_VALID && O_RDATA == $past(setup_q)) // see RQ21
    else $error("read command answer wrong");
  a_bad_proc_ignored: assert property (state_q == orc_pkg::ST_IDLE && I_HOMING_START && !proc_ok |=> !O_HOMING_BUSY) // see RQ1
    else $error("reserved procedure code started homing");
  a_p0_home_stop: assert property (state_q == orc_pkg::ST_SEEK && base == orc_pkg::PROC_0 && home_rise && !I_HIGH_SPEED
                                   |=> O_STOP_NOW && home_clr_q) // see RQ2
    else $error("procedure 0 missed stop or clear");
  a_p1_backoff: assert property (s_p1_home_edge |=> s_back_at_approach ##0 !home_clr_q) // see RQ3
    else $error("procedure 1 did not back off at approach speed");
  a_index_stop: assert property (state_q == orc_pkg::ST_INDEX && idx_done &&
                                 (base == orc_pkg::PROC_2 || base == orc_pkg::PROC_4 || base == orc_pkg::PROC_7)
                                 |=> O_STOP_NOW && home_clr_q) // see RQ4
    else $error("index count completion did not stop and clear");
  a_index_bound: assert property (state_q == orc_pkg::ST_INDEX |-> idx_cnt_q <= idx_field) // see RQ12
    else $error("index counter passed the programmed count");
  a_p6_limit_stop: assert property (state_q == orc_pkg::ST_SEEK && base == orc_pkg::PROC_6 && limit_rise && !lim_dec
                                    |=> O_STOP_NOW && !O_DECEL_STOP ##1 O_REVERSE) // see RQ8
    else $error("procedure 6 limit stop wrong");
  a_zero_run_end: assert property (state_q == orc_pkg::ST_ZERO && I_SECOND_COUNTER_ZERO
                                   |=> O_STOP_NOW && !O_ZERO_RUN && !O_HOMING_BUSY) // see RQ11
    else $error("zero run did not end at counter zero");
  a_gate_fourth: assert property (gate4 && I_MOTION_ACTIVE_OUTPUT |=> !O_CNT_UP[3]) // see RQ16
    else $error("fourth counter counted while motion active");
  a_second_enc_src: assert property (src2_sel == orc_pkg::SRC_CODE_0 && I_ENCODER_PHASES && !hold[1] && !I_CORRECTION_ACTIVE
                                     |=> O_CNT_UP[1]) // see RQ13
    else $error("second counter missed encoder pulse");
  a_third_dev: assert property (src3_sel == orc_pkg::SRC_CODE_0 && I_COMMAND_PULSE && !I_ENCODER_PHASES && !hold[2] &&
                                !I_CORRECTION_ACTIVE |=> O_CNT_UP[2] && !O_CNT_DN[2]) // see RQ14
    else $error("third counter deviation count wrong");
endmodule

// File: orc_axis_model.sv
`timescale 1ns/1ns
module orc_axis_model (
  // clock
  input wire logic i_clk,
  // motion commands
  input wire logic i_busy,
  input wire logic i_reverse,
  input wire logic i_zero_run,
  // sensor pins
  output logic o_home,
  output logic o_limit,
  output logic o_index,
  output logic o_zero
);
  int pos_q;
  int zr_q;
  // axis keeps moving after a stop request: worst case for the sequencer
  always_ff @(posedge i_clk) begin
    pos_q <= !i_busy ? 0 : i_reverse ? pos_q - 1 : pos_q + 1;
    zr_q <= i_zero_run ? zr_q + 1 : 0;
  end
  assign o_home = pos_q >= 20 && pos_q < 40;
  assign o_limit = pos_q >= 60;
  // index mark every eight steps, only while moving
  assign o_index = i_busy && pos_q[2:0] == 3'h0 && pos_q != 0;
  assign o_zero = zr_q >= 10;
endmodule

// File: origin_return_counter_config_bench.sv
`timescale 1ns/1ns
module origin_return_counter_config_bench;
  logic clk = 0;
  logic srst = 1;
  logic [7:0] addr = 8'h00;
  logic [7:0] code = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] cdata = 32'h0000_0000;
  logic wr = 0, rd = 0, stb = 0, cclr = 0, start = 0, hs = 0, ldo = 0;
  logic mact = 0, corr = 0, cmd = 0, enc = 0, pul = 0;
  logic home, lim, idx, szero, rvalid, stop, dec, rev, appr, busy, zrun;
  logic [31:0] rdata;
  logic [3:0] up, dn, clr, clr_acc;
  logic stop_acc, zr_acc, rev_acc, appr_acc;
  logic [31:0] c;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n4;
  always #4 clk = ~clk;
  orc_top i_orc_top (.I_REF_CLK(clk), .I_SRST(srst), .I_BUS_ADDR(addr), .I_BUS_WR(wr),
    .I_BUS_RD(rd), .I_BUS_WDATA(wdata), .I_CMD_STB(stb), .I_CMD_CODE(code), .I_CMD_WDATA(cdata),
    .O_RDATA(rdata), .O_RDATA_VALID(rvalid), .I_HOME_SENSOR(home), .I_LIMIT_SWITCH_INPUT(lim),
    .I_ENCODER_INDEX(idx), .I_COUNTER_RESET_INPUT(cclr), .I_HOMING_START(start), .I_HIGH_SPEED(hs),
    .I_LIMIT_DECELERATE_OPTION(ldo), .I_MOTION_ACTIVE_OUTPUT(mact), .I_CORRECTION_ACTIVE(corr),
    .I_SECOND_COUNTER_ZERO(szero), .I_COMMAND_PULSE(cmd), .I_ENCODER_PHASES(enc),
    .I_MANUAL_PULSER_PHASES(pul), .O_STOP_NOW(stop), .O_DECEL_STOP(dec), .O_REVERSE(rev),
    .O_APPROACH_SPEED(appr), .O_HOMING_BUSY(busy), .O_ZERO_RUN(zrun), .O_CNT_UP(up), .O_CNT_DN(dn),
    .O_CNT_CLR(clr));
  orc_axis_model i_orc_axis_model (.i_clk(clk), .i_busy(busy), .i_reverse(rev), .i_zero_run(zrun),
    .o_home(home), .o_limit(lim), .o_index(idx), .o_zero(szero));
  always @(posedge clk) begin
    clr_acc <= clr_acc | clr;
    stop_acc <= stop_acc | stop | dec;
    zr_acc <= zr_acc | zrun;
    rev_acc <= rev_acc | rev;
    appr_acc <= appr_acc | appr;
    cycles++;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic put(logic direct, logic [31:0] d, logic [7:0] a);
    addr = a;
    wdata = d;
    cdata = d;
    code = orc_pkg::CMD_WRITE_SETUP;
    wr = direct;
    stb = !direct;
    tick();
    wr = 0;
    stb = 0;
    // idle edge so a following call never retoggles a strobe in one step
    tick();
  endtask
  task automatic get(logic direct, logic [31:0] exp);
    addr = orc_pkg::SETUP_OFFSET;
    code = orc_pkg::CMD_READ_SETUP;
    rd = direct;
    stb = !direct;
    tick();
    rd = 0;
    stb = 0;
    check("valid", rvalid, 1);
    check("setup", rdata, exp);
    tick();
  endtask
  // expected {down, up} strobes for one pulse of source s (0 cmd, 1 enc, 2 pulser)
  function automatic logic [7:0] exp_cnt(int s, logic [31:0] k);
    logic [2:0] v;
    logic [7:0] r;
    v = 3'b001 << s;
    r = 8'h00;
    r[0] = v[0];
    r[1] = k[9:8] == 2'h0 ? v[1] : k[9:8] == 2'h1 ? v[0] : k[9:8] == 2'h2 && v[2];
    r[2] = k[11:10] == 2'h2 ? v[1] : k[11:10] != 2'h3 && v[0];
    r[6] = k[11:10] == 2'h0 ? v[1] : k[11:10] != 2'h3 && v[2];
    r[3] = k[13:12] != 2'h3 && v[k[13:12]] && !(k[14] && mact);
    for (int n = 0; n < 4; n++) begin
      if ((n > 0 && k[28 + n]) || (corr && !k[24 + n])) begin
        r[n] = 0;
        r[n + 4] = 0;
      end
    end
    return r;
  endfunction
  initial begin
    void'($urandom(58847));
    repeat (12) @(posedge clk);
    #1;
    srst = 0;
    get(1, orc_pkg::SETUP_RESET);
    for (int i = 0; i < 8; i++) begin
      c = $urandom();
      put(i % 2, c, orc_pkg::SETUP_OFFSET);
      put(1, ~c, 8'h88);
      get(!(i % 2), c & orc_pkg::SETUP_WRITE_MASK);
    end
    $display("test registers done");
    for (int i = 0; i < 41; i++) begin
      c = i == 40 ? 32'hE000_0000 : $urandom();
      if (c[13:12] == 2'h3) begin
        c[13:12] = 2'h0;
      end
      mact = $urandom();
      corr = $urandom();
      put(i % 2, c, orc_pkg::SETUP_OFFSET);
      n4 = $urandom_range(2);
      {pul, enc, cmd} = 3'b001 << n4;
      tick();
      {pul, enc, cmd} = 3'b000;
      check("strobes", {dn, up}, exp_cnt(n4, c));
    end
    mact = 0;
    corr = 0;
    put(1, 32'h0000_3000, orc_pkg::SETUP_OFFSET);
    n4 = 0;
    repeat (8) begin
      tick();
      n4 += up[3];
    end
    check("half clock", n4, 4);
    c = $urandom() & 32'h000F_0000;
    put(0, c, orc_pkg::SETUP_OFFSET);
    clr_acc = 0;
    cclr = 1;
    repeat (8) tick();
    cclr = 0;
    check("ext clear", clr_acc, c[19:16]);
    $display("test counters done");
    for (int p = 0; p < 16; p++) begin
      c = $urandom() & 32'h00FF_00F0;
      c[3:0] = p;
      hs = $urandom();
      ldo = $urandom();
      put(p % 2, c, orc_pkg::SETUP_OFFSET);
      repeat (8) tick();
      clr_acc = 0;
      stop_acc = 0;
      zr_acc = 0;
      rev_acc = 0;
      appr_acc = 0;
      start = 1;
      tick();
      start = 0;
      check("busy", busy, p < 13);
      for (int k = 0; k < 3000 && busy !== 1'b0; k++) begin
        tick();
      end
      check("done", busy, 0);
      repeat (4) tick();
      check("stop", stop_acc, p < 13);
      check("home clear", clr_acc, p < 13 ? c[23:20] : 4'h0);
      check("zero run", zr_acc, p > 8 && p < 13);
      check("reverse", rev_acc, (16'h08F2 >> p) & 1);
      check("approach", appr_acc, (16'h00D2 >> p) & 1);
    end
    $display("test homing done");
    report_and_stop();
  end
endmodule
